//--- logic/exec_slice_pkg.sv
// Purpose: Shared constants and types for the set, skip, subtract, swap, table-read and XOR execution slice.
// Assumes: One core clock; data memory and program memory sit outside the block.
// Notes: Register indices are word indices on the plain register port.
package exec_slice_pkg;

   // ----------------------------------------
   // Register map and field layout
   // ----------------------------------------
   localparam logic [2:0] REG_WORK = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_TABLE_POINTER = 3'h2;
   localparam logic [2:0] REG_TABLE_HIGH = 3'h3;
   localparam int FLAG_BORROW_OUT = 0;
   localparam int FLAG_HALF_BORROW = 1;
   localparam int FLAG_NULL_RESULT = 2;
   localparam int FLAG_SIGNED_LIMIT = 3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [8:0] ONE_WIDE = 9'h001;
   localparam logic [4:0] ONE_NIBBLE = 5'h01;

   // ----------------------------------------
   // Operations handled by this slice
   // ----------------------------------------
   typedef enum logic [4:0] {
      OP_NONE = 5'h00,
      OP_SET_BYTE = 5'h01,
      OP_SET_BIT = 5'h02,
      OP_INC_SKIP_ZERO = 5'h03,
      OP_INC_TO_WORK_SKIP_ZERO = 5'h04,
      OP_DEC_TO_WORK_SKIP_NULL = 5'h05,
      OP_SKIP_BIT_HIGH = 5'h06,
      OP_SKIP_NULL_BIT = 5'h07,
      OP_SKIP_NULL_BYTE = 5'h08,
      OP_COPY_SKIP_NULL = 5'h09,
      OP_MINUS_TO_WORK = 5'h0A,
      OP_MINUS_TO_MEMORY = 5'h0B,
      OP_MINUS_IMMEDIATE = 5'h0C,
      OP_NIBBLE_EXCHANGE = 5'h0D,
      OP_NIBBLE_EXCHANGE_TO_WORK = 5'h0E,
      OP_TABLE_READ_CURRENT_PAGE = 5'h0F,
      OP_TABLE_READ_FINAL_PAGE = 5'h10,
      OP_EXCLUSIVE_OR_TO_WORK = 5'h11,
      OP_EXCLUSIVE_OR_TO_MEMORY = 5'h12,
      OP_EXCLUSIVE_OR_IMMEDIATE = 5'h13
   } op_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_DUMMY = 2'h1,
      ST_TABLE_FETCH = 2'h2,
      ST_TABLE_LOAD = 2'h3
   } state_type;

   // One issued instruction with its already-read memory operand.
   typedef struct packed {
      op_type op;
      logic [2:0] bit_sel;
      logic [7:0] immediate;
      logic [7:0] mem_data;
   } exec_req_type;

   typedef struct packed {
      logic signed_limit_flag;
      logic null_result_flag;
      logic half_borrow_flag;
      logic borrow_out_flag;
   } flags_type;

endpackage

//--- logic/mcu_exec_set_skip_sub_xor.sv
// Purpose: Execution datapath for byte/bit set, skip, subtract, nibble swap, table read and XOR.
// Assumes: The issuing pipeline supplies the addressed byte with each request and honours exec_ready.
// Notes: Results leave on registered outputs one edge after the request is taken, except a table read, whose byte is written two edges later still.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module mcu_exec_set_skip_sub_xor #(
   parameter int ROM_ADDR_W = 12,
   parameter int ROM_W = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic exec_valid,
   input exec_slice_pkg::exec_req_type exec_req,
   output logic exec_ready,
   input wire logic [ROM_ADDR_W-9:0] pc_page,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   output logic skip_flush,
   output logic rom_rd,
   output logic [ROM_ADDR_W-1:0] rom_addr,
   input wire logic [ROM_W-1:0] rom_rdata,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);

   // ----------------------------------------
   // Architectural state
   // ----------------------------------------
   exec_slice_pkg::state_type state;
   exec_slice_pkg::flags_type flags;
   logic [7:0] work_register;
   logic [7:0] table_pointer;
   logic [ROM_W-9:0] table_high_latch;
   logic take;
   logic [7:0] next_value;
   logic to_mem;
   logic to_work;
   logic skip;
   logic upd_sub;
   logic upd_null;
   logic is_table;
   exec_slice_pkg::flags_type next_flags;

   // Subtraction as work plus complement plus one; carry out means no borrow.
   function automatic exec_slice_pkg::flags_type minus_flags(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] sum;
      logic [4:0] low;
      exec_slice_pkg::flags_type f;
      sum = {1'b0, a} + {1'b0, ~b} + exec_slice_pkg::ONE_WIDE;
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + exec_slice_pkg::ONE_NIBBLE;
      f.borrow_out_flag = sum[8];
      f.half_borrow_flag = low[4];
      f.null_result_flag = (sum[7:0] == exec_slice_pkg::RESET_BYTE);
      f.signed_limit_flag = (a[7] ^ b[7]) & (a[7] ^ sum[7]);
      return f;
   endfunction

   function automatic logic [7:0] swap_nibbles(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction

   // Only a fresh request is taken; table reads and dummy cycles hold the issue side off.
   assign exec_ready = (state == exec_slice_pkg::ST_RUN);
   assign take = exec_valid && exec_ready;
   assign is_table = (exec_req.op == exec_slice_pkg::OP_TABLE_READ_CURRENT_PAGE) ||
                     (exec_req.op == exec_slice_pkg::OP_TABLE_READ_FINAL_PAGE);

   // ----------------------------------------
   // Operation decode and arithmetic
   // ----------------------------------------
   always_comb begin
      next_value = exec_req.mem_data;
      to_mem = 1'b0;
      to_work = 1'b0;
      skip = 1'b0;
      upd_sub = 1'b0;
      upd_null = 1'b0;
      next_flags = minus_flags(work_register, exec_req.mem_data);
      case (exec_req.op)
         exec_slice_pkg::OP_SET_BYTE: begin
            next_value = exec_slice_pkg::ALL_ONES;
            to_mem = 1'b1;
         end
         exec_slice_pkg::OP_SET_BIT: begin
            next_value = exec_req.mem_data | (exec_slice_pkg::ONE_BYTE << exec_req.bit_sel);
            to_mem = 1'b1;
         end
         exec_slice_pkg::OP_INC_SKIP_ZERO: begin
            next_value = exec_req.mem_data + exec_slice_pkg::ONE_BYTE;
            to_mem = 1'b1;
            skip = (next_value == exec_slice_pkg::RESET_BYTE);
         end
         exec_slice_pkg::OP_INC_TO_WORK_SKIP_ZERO: begin
            next_value = exec_req.mem_data + exec_slice_pkg::ONE_BYTE;
            to_work = 1'b1;
            skip = (next_value == exec_slice_pkg::RESET_BYTE);
         end
         exec_slice_pkg::OP_DEC_TO_WORK_SKIP_NULL: begin
            next_value = exec_req.mem_data - exec_slice_pkg::ONE_BYTE;
            to_work = 1'b1;
            skip = (next_value == exec_slice_pkg::RESET_BYTE);
         end
         exec_slice_pkg::OP_SKIP_BIT_HIGH: begin
            skip = exec_req.mem_data[exec_req.bit_sel];
         end
         exec_slice_pkg::OP_SKIP_NULL_BIT: begin
            skip = !exec_req.mem_data[exec_req.bit_sel];
         end
         exec_slice_pkg::OP_SKIP_NULL_BYTE: begin
            skip = (exec_req.mem_data == exec_slice_pkg::RESET_BYTE);
         end
         exec_slice_pkg::OP_COPY_SKIP_NULL: begin
            to_work = 1'b1;
            skip = (exec_req.mem_data == exec_slice_pkg::RESET_BYTE);
         end
         exec_slice_pkg::OP_MINUS_TO_WORK: begin
            next_value = work_register + ~exec_req.mem_data + exec_slice_pkg::ONE_BYTE;
            to_work = 1'b1;
            upd_sub = 1'b1;
         end
         exec_slice_pkg::OP_MINUS_TO_MEMORY: begin
            next_value = work_register + ~exec_req.mem_data + exec_slice_pkg::ONE_BYTE;
            to_mem = 1'b1;
            upd_sub = 1'b1;
         end
         exec_slice_pkg::OP_MINUS_IMMEDIATE: begin
            next_value = work_register + ~exec_req.immediate + exec_slice_pkg::ONE_BYTE;
            next_flags = minus_flags(work_register, exec_req.immediate);
            to_work = 1'b1;
            upd_sub = 1'b1;
         end
         exec_slice_pkg::OP_NIBBLE_EXCHANGE: begin
            next_value = swap_nibbles(exec_req.mem_data);
            to_mem = 1'b1;
         end
         exec_slice_pkg::OP_NIBBLE_EXCHANGE_TO_WORK: begin
            next_value = swap_nibbles(exec_req.mem_data);
            to_work = 1'b1;
         end
         exec_slice_pkg::OP_EXCLUSIVE_OR_TO_WORK: begin
            next_value = work_register ^ exec_req.mem_data;
            to_work = 1'b1;
            upd_null = 1'b1;
         end
         exec_slice_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: begin
            next_value = work_register ^ exec_req.mem_data;
            to_mem = 1'b1;
            upd_null = 1'b1;
         end
         exec_slice_pkg::OP_EXCLUSIVE_OR_IMMEDIATE: begin
            next_value = work_register ^ exec_req.immediate;
            to_work = 1'b1;
            upd_null = 1'b1;
         end
         default: begin
            next_value = exec_req.mem_data;
         end
      endcase
   end

   // ----------------------------------------
   // Sequencing: dummy cycle and table fetch
   // ----------------------------------------
   // A met skip costs exactly one extra cycle, during which the prefetched word is thrown away.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= exec_slice_pkg::ST_RUN;
      end else begin
         case (state)
            exec_slice_pkg::ST_RUN: begin
               if (take && is_table) begin
                  state <= exec_slice_pkg::ST_TABLE_FETCH;
               end else if (take && skip) begin
                  state <= exec_slice_pkg::ST_DUMMY;
               end
            end
            exec_slice_pkg::ST_TABLE_FETCH: begin
               state <= exec_slice_pkg::ST_TABLE_LOAD;
            end
            default: begin
               state <= exec_slice_pkg::ST_RUN;
            end
         endcase
      end
   end

   // The flush pulse stands for the dummy cycle only.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         skip_flush <= 1'b0;
      end else begin
         skip_flush <= take && skip && !is_table;
      end
   end

   // Program memory address: current page from the counter, or the last page (all ones).
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rom_rd <= 1'b0;
         rom_addr <= '0;
      end else begin
         rom_rd <= take && is_table;
         if (take && exec_req.op == exec_slice_pkg::OP_TABLE_READ_CURRENT_PAGE) begin
            rom_addr <= {pc_page, table_pointer};
         end else if (take && exec_req.op == exec_slice_pkg::OP_TABLE_READ_FINAL_PAGE) begin
            rom_addr <= {{(ROM_ADDR_W-8){1'b1}}, table_pointer};
         end
      end
   end

   // ----------------------------------------
   // Data memory write port
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_wr <= 1'b0;
         mem_wdata <= exec_slice_pkg::RESET_BYTE;
      end else if (state == exec_slice_pkg::ST_TABLE_LOAD) begin
         mem_wr <= 1'b1;
         mem_wdata <= rom_rdata[7:0];
      end else begin
         mem_wr <= take && to_mem;
         if (take && to_mem) begin
            mem_wdata <= next_value;
         end
      end
   end

   // The high part of the fetched word lands in its latch in the same edge as the low byte write.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         table_high_latch <= '0;
      end else if (state == exec_slice_pkg::ST_TABLE_LOAD) begin
         table_high_latch <= rom_rdata[ROM_W-1:8];
      end
   end

   // ----------------------------------------
   // Work register, flags and table pointer
   // ----------------------------------------
   // An instruction result wins over a register write in the same cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         work_register <= exec_slice_pkg::RESET_BYTE;
      end else if (take && to_work) begin
         work_register <= next_value;
      end else if (reg_wr && reg_addr == exec_slice_pkg::REG_WORK) begin
         work_register <= reg_wdata;
      end
   end

   // Only subtraction and XOR touch flags; every other operation leaves them as they were.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flags <= '0;
      end else if (take && upd_sub) begin
         flags <= next_flags;
      end else if (take && upd_null) begin
         flags.null_result_flag <= (next_value == exec_slice_pkg::RESET_BYTE);
      end else if (reg_wr && reg_addr == exec_slice_pkg::REG_STATUS) begin
         flags.borrow_out_flag <= reg_wdata[exec_slice_pkg::FLAG_BORROW_OUT];
         flags.half_borrow_flag <= reg_wdata[exec_slice_pkg::FLAG_HALF_BORROW];
         flags.null_result_flag <= reg_wdata[exec_slice_pkg::FLAG_NULL_RESULT];
         flags.signed_limit_flag <= reg_wdata[exec_slice_pkg::FLAG_SIGNED_LIMIT];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         table_pointer <= exec_slice_pkg::RESET_BYTE;
      end else if (reg_wr && reg_addr == exec_slice_pkg::REG_TABLE_POINTER) begin
         table_pointer <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   // Read data stand only in the cycle after the strobe; unmapped indices read zero.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= exec_slice_pkg::RESET_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            exec_slice_pkg::REG_WORK: reg_rdata <= work_register;
            exec_slice_pkg::REG_STATUS: reg_rdata <= {4'h0, flags};
            exec_slice_pkg::REG_TABLE_POINTER: reg_rdata <= table_pointer;
            exec_slice_pkg::REG_TABLE_HIGH: reg_rdata <= 8'(table_high_latch);
            default: reg_rdata <= exec_slice_pkg::RESET_BYTE;
         endcase
      end else begin
         reg_rdata <= exec_slice_pkg::RESET_BYTE;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence dummy_seq;
      skip_flush && !exec_ready ##1 exec_ready;
   endsequence

   sequence table_seq;
      rom_rd && !exec_ready ##1 !rom_rd && !exec_ready ##1 mem_wr && exec_ready;
   endsequence

   skip_dummy_cycle_a: assert property (take && skip && !is_table |=> dummy_seq)
      else $error("Met skip did not give one dummy cycle.");
   no_skip_single_a: assert property (take && !skip && !is_table |=> exec_ready && !skip_flush)
      else $error("Unmet skip stalled the issue side.");
   set_byte_ones_a: assert property (take && exec_req.op == exec_slice_pkg::OP_SET_BYTE
      |=> mem_wr && mem_wdata == 8'hFF && $stable(flags))
      else $error("Byte set did not write all ones.");
   set_bit_only_a: assert property (take && exec_req.op == exec_slice_pkg::OP_SET_BIT
      |=> mem_wr && mem_wdata[$past(exec_req.bit_sel)] && $stable(flags)
          && ((mem_wdata ^ $past(exec_req.mem_data)) & ~(8'h01 << $past(exec_req.bit_sel))) == 8'h00)
      else $error("Bit set disturbed other bits.");
   inc_memory_skip_a: assert property (take && exec_req.op == exec_slice_pkg::OP_INC_SKIP_ZERO
      |=> mem_wr && mem_wdata == 8'($past(exec_req.mem_data) + 8'h01)
          && skip_flush == ($past(exec_req.mem_data) == 8'hFF))
      else $error("Increment in memory or its skip is wrong.");
   inc_work_skip_a: assert property (take && exec_req.op == exec_slice_pkg::OP_INC_TO_WORK_SKIP_ZERO
      |=> !mem_wr && work_register == 8'($past(exec_req.mem_data) + 8'h01)
          && skip_flush == (work_register == 8'h00))
      else $error("Increment to work register is wrong.");
   dec_work_skip_a: assert property (take && exec_req.op == exec_slice_pkg::OP_DEC_TO_WORK_SKIP_NULL
      |=> !mem_wr && work_register == 8'($past(exec_req.mem_data) - 8'h01)
          && skip_flush == ($past(exec_req.mem_data) == 8'h01))
      else $error("Decrement to work register is wrong.");
   bit_high_skip_a: assert property (take && exec_req.op == exec_slice_pkg::OP_SKIP_BIT_HIGH
      |=> !mem_wr && skip_flush == $past(exec_req.mem_data[exec_req.bit_sel]) && $stable(flags))
      else $error("Bit-high skip decision is wrong.");
   bit_low_skip_a: assert property (take && exec_req.op == exec_slice_pkg::OP_SKIP_NULL_BIT
      |=> !mem_wr && skip_flush != $past(exec_req.mem_data[exec_req.bit_sel]))
      else $error("Bit-low skip decision is wrong.");
   byte_null_skip_a: assert property (take && exec_req.op == exec_slice_pkg::OP_SKIP_NULL_BYTE
      |=> !mem_wr && skip_flush == ($past(exec_req.mem_data) == 8'h00) && $stable(work_register))
      else $error("Byte-null skip decision is wrong.");
   copy_skip_a: assert property (take && exec_req.op == exec_slice_pkg::OP_COPY_SKIP_NULL
      |=> work_register == $past(exec_req.mem_data) && skip_flush == (work_register == 8'h00))
      else $error("Copy with skip is wrong.");
   minus_work_a: assert property (take && exec_req.op == exec_slice_pkg::OP_MINUS_TO_WORK
      |=> work_register == 8'($past(work_register) - $past(exec_req.mem_data))
          && flags.borrow_out_flag == ($past(work_register) >= $past(exec_req.mem_data)))
      else $error("Subtraction into work register is wrong.");
   minus_memory_a: assert property (take && exec_req.op == exec_slice_pkg::OP_MINUS_TO_MEMORY
      |=> mem_wr && mem_wdata == 8'($past(work_register) - $past(exec_req.mem_data))
          && flags.null_result_flag == (mem_wdata == 8'h00) && $stable(work_register))
      else $error("Subtraction into memory is wrong.");
   minus_imm_a: assert property (take && exec_req.op == exec_slice_pkg::OP_MINUS_IMMEDIATE
      |=> work_register == 8'($past(work_register) - $past(exec_req.immediate))
          && flags.half_borrow_flag == ($past(work_register[3:0]) >= $past(exec_req.immediate[3:0])))
      else $error("Immediate subtraction is wrong.");
   swap_memory_a: assert property (take && exec_req.op == exec_slice_pkg::OP_NIBBLE_EXCHANGE
      |=> mem_wr && mem_wdata == {$past(exec_req.mem_data[3:0]), $past(exec_req.mem_data[7:4])}
          && $stable(flags))
      else $error("Nibble swap in memory is wrong.");
   swap_work_a: assert property (take && exec_req.op == exec_slice_pkg::OP_NIBBLE_EXCHANGE_TO_WORK
      |=> !mem_wr && work_register == {$past(exec_req.mem_data[3:0]), $past(exec_req.mem_data[7:4])})
      else $error("Nibble swap to work register is wrong.");
   table_current_a: assert property (take && exec_req.op == exec_slice_pkg::OP_TABLE_READ_CURRENT_PAGE
      |=> rom_addr == {$past(pc_page), $past(table_pointer)} ##0 table_seq)
      else $error("Current-page table read sequence is wrong.");
   table_final_a: assert property (take && exec_req.op == exec_slice_pkg::OP_TABLE_READ_FINAL_PAGE
      |=> rom_addr[ROM_ADDR_W-1:8] == '1 ##0 table_seq)
      else $error("Final-page table read sequence is wrong.");
   table_load_a: assert property (state == exec_slice_pkg::ST_TABLE_LOAD
      |=> mem_wr && mem_wdata == $past(rom_rdata[7:0]) && table_high_latch == $past(rom_rdata[ROM_W-1:8])
          && $stable(flags))
      else $error("Table word did not land in memory and latch.");
   xor_work_a: assert property (take && exec_req.op == exec_slice_pkg::OP_EXCLUSIVE_OR_TO_WORK
      |=> work_register == ($past(work_register) ^ $past(exec_req.mem_data))
          && flags.null_result_flag == (work_register == 8'h00)
          && flags.borrow_out_flag == $past(flags.borrow_out_flag))
      else $error("XOR into work register is wrong.");
   xor_memory_a: assert property (take && exec_req.op == exec_slice_pkg::OP_EXCLUSIVE_OR_TO_MEMORY
      |=> mem_wr && mem_wdata == ($past(work_register) ^ $past(exec_req.mem_data))
          && flags.null_result_flag == (mem_wdata == 8'h00))
      else $error("XOR into memory is wrong.");
   xor_imm_a: assert property (take && exec_req.op == exec_slice_pkg::OP_EXCLUSIVE_OR_IMMEDIATE
      |=> work_register == ($past(work_register) ^ $past(exec_req.immediate))
          && flags.signed_limit_flag == $past(flags.signed_limit_flag))
      else $error("XOR with immediate is wrong.");

endmodule

//--- test/rom_model.sv
// Purpose: Program memory model for table reads.
// Assumes: The word is due in the cycle after rom_rd.
// Notes: Between reads the lines invert each cycle, so a stale word never passes.
`timescale 1ns/100ps
module rom_model (
   input wire logic clk,
   input wire logic rom_rd,
   input wire logic [11:0] rom_addr,
   output logic [15:0] rom_rdata
);
   // Content is a fixed function of the address, so the bench can predict it.
   initial rom_rdata = 16'h0000;
   always @(posedge clk) begin
      rom_rdata <= rom_rd ? {rom_addr[11:4], rom_addr[7:0] ^ 8'h3C} : ~rom_rdata;
   end
endmodule

//--- test/mcu_exec_set_skip_sub_xor_tb_top.sv
// Purpose: Self-checking bench for the execution slice.
// Assumes: Requests are spaced so the dummy and table cycles have ended.
// Notes: Notes are queued at issue and paired with results as they appear.
`timescale 1ns/100ps
module mcu_exec_set_skip_sub_xor_tb_top;
   logic clk = 1'b0, arst_n = 1'b0, exec_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
   exec_slice_pkg::exec_req_type exec_req = '0;
   logic [3:0] pc_page = 4'h0, flags = 4'h0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, work, latch = 8'h00, tp, reg_rdata, mem_wdata;
   logic exec_ready, mem_wr, skip_flush, rom_rd;
   logic [11:0] rom_addr;
   logic [15:0] rom_rdata;
   logic [9:0] mq[$];
   logic [7:0] rq[$];
   int bad_count = 0, checks = 0;
   // Free-running 50 ns clock.
   initial forever #25 clk = ~clk;
   mcu_exec_set_skip_sub_xor uut (.clk(clk), .arst_n(arst_n), .exec_valid(exec_valid), .exec_req(exec_req),
      .exec_ready(exec_ready), .pc_page(pc_page), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .skip_flush(skip_flush), .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   rom_model rom (.clk(clk), .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_rdata(rom_rdata));
   task automatic check(string what, logic [9:0] exp, logic [9:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // An empty memory queue yields an impossible note, so an unexpected write or flush fails; an empty read queue yields EE.
   always @(posedge clk) begin
      if (rd_q) check("reg_rdata", {2'b00, rq.size() > 0 ? rq.pop_front() : 8'hEE}, {2'b00, reg_rdata});
      if (mem_wr || skip_flush) check("mem", mq.size() > 0 ? mq.pop_front() : 10'h3FF,
         {mem_wr, skip_flush, mem_wr ? mem_wdata : 8'h00});
      rd_q = reg_rd;
   end
   task automatic reg_op(logic w, logic [2:0] a, logic [7:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) rq.push_back(d);
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // One idle edge, so a following call never drives a strobe twice in one step.
      @(posedge clk);
   endtask
   // Difference by complement plus one, with all four arithmetic flags.
   function automatic logic [7:0] sub(logic [7:0] a, logic [7:0] b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      flags = {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
      return s[7:0];
   endfunction
   function automatic logic [7:0] xr(logic [7:0] b);
      flags[2] = (work ^ b) == 8'h00;
      return work ^ b;
   endfunction
   task automatic issue(exec_slice_pkg::op_type op, logic [2:0] b, logic [7:0] im, md, logic [3:0] pg);
      logic w, s;
      logic [7:0] d;
      logic [3:0] x;
      {w, s, d} = 10'h000;
      x = op == exec_slice_pkg::OP_TABLE_READ_FINAL_PAGE ? 4'hF : pg;
      case (op)
         exec_slice_pkg::OP_SET_BYTE: {w, d} = {1'b1, exec_slice_pkg::ALL_ONES};
         exec_slice_pkg::OP_SET_BIT: {w, d} = {1'b1, md | (8'h01 << b)};
         exec_slice_pkg::OP_INC_SKIP_ZERO: {w, s, d} = {1'b1, md == 8'hFF, md + 8'h01};
         exec_slice_pkg::OP_INC_TO_WORK_SKIP_ZERO: {s, work} = {md == 8'hFF, md + 8'h01};
         exec_slice_pkg::OP_DEC_TO_WORK_SKIP_NULL: {s, work} = {md == 8'h01, md - 8'h01};
         exec_slice_pkg::OP_SKIP_BIT_HIGH: s = md[b];
         exec_slice_pkg::OP_SKIP_NULL_BIT: s = !md[b];
         exec_slice_pkg::OP_SKIP_NULL_BYTE: s = md == 8'h00;
         exec_slice_pkg::OP_COPY_SKIP_NULL: {s, work} = {md == 8'h00, md};
         exec_slice_pkg::OP_MINUS_TO_WORK: work = sub(work, md);
         exec_slice_pkg::OP_MINUS_TO_MEMORY: {w, d} = {1'b1, sub(work, md)};
         exec_slice_pkg::OP_MINUS_IMMEDIATE: work = sub(work, im);
         exec_slice_pkg::OP_NIBBLE_EXCHANGE: {w, d} = {1'b1, md[3:0], md[7:4]};
         exec_slice_pkg::OP_NIBBLE_EXCHANGE_TO_WORK: work = {md[3:0], md[7:4]};
         exec_slice_pkg::OP_EXCLUSIVE_OR_TO_WORK: work = xr(md);
         exec_slice_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: {w, d} = {1'b1, xr(md)};
         exec_slice_pkg::OP_EXCLUSIVE_OR_IMMEDIATE: work = xr(im);
         default: {w, latch, d} = {1'b1, x, tp[7:4], tp ^ 8'h3C};
      endcase
      if (w || s) mq.push_back({w, s, d});
      exec_req <= '{op, b, im, md};
      pc_page <= pg;
      exec_valid <= 1'b1;
      @(posedge clk);
      exec_valid <= 1'b0;
      repeat (3) @(posedge clk);
      reg_op(1'b0, 3'h0, work);
      reg_op(1'b0, 3'h1, {4'h0, flags});
      reg_op(1'b0, 3'h3, latch);
   endtask
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0 && mq.size() == 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Six rounds of every operation; the first three use the wrap and zero bytes.
   initial begin
      int k, i;
      logic [7:0] md;
      void'($urandom(57));
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 6; k++) begin
         for (i = 1; i < 20; i++) begin
            md = k == 0 ? 8'hFF : k == 1 ? 8'h01 : k == 2 ? 8'h00 : 8'($urandom);
            work = 8'($urandom);
            tp = 8'($urandom);
            reg_op(1'b1, 3'h0, work);
            reg_op(1'b1, 3'h2, tp);
            issue(exec_slice_pkg::op_type'(i), 3'($urandom), 8'($urandom), md, 4'($urandom));
         end
         $display("Round %0d done", k);
      end
      reg_op(1'b0, 3'h5, 8'h00);
      repeat (3) @(posedge clk);
      summarize();
   end
   // A hang is cut short well beyond the expected run length.
   initial begin
      #1000000;
      bad_count++;
      summarize();
   end
endmodule
